// ==== src/sdm_cfg.svh ====
`ifndef SDM_CFG_SVH
`define SDM_CFG_SVH
// ---------------------------------------------------------------
// Frame layout
// ---------------------------------------------------------------
`define SDM_FRAME_BITS   8
`define SDM_CMD_WR_BIT   7
`define SDM_CMD_SEL_MSB  6
`define SDM_CMD_SEL_LSB  4
`define SDM_SEL_DCR      3'h7
`define SDM_SBM_BIT      3
`define SDM_MUX_MSB      2
`define SDM_MUX_LSB      0
// ---------------------------------------------------------------
// Sense multiplexer codes, reset values and control read header
// ---------------------------------------------------------------
`define SDM_MUX_LAST_CH  3'h5
`define SDM_MUX_HIZ      3'h6
`define SDM_MUX_STBY     3'h7
`define SDM_MUX_RST      3'h6
`define SDM_TER_RST      1'b1
`define SDM_DCR_RD_HDR   4'h7
// ---------------------------------------------------------------
// Settle count in reference clock cycles; FIFO depth in words
// ---------------------------------------------------------------
`define SDM_SETTLE_CYC   3'h4
`define SDM_FIFO_DEPTH   32
`endif

// ==== src/sdm_pkg.sv ====
package sdm_pkg;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   // Standard diagnosis word
   typedef struct packed {
      logic       zero;
      logic       limp_home_flag;
      logic [5:0] channel_fault_flag;
   } sdm_diag_type;
   // Received command frame
   typedef struct packed {
      logic       wr;
      logic       bank_bit;
      logic [1:0] addr;
      logic [3:0] payload;
   } sdm_frame_type;
   // Frame tracking states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_FRAME  = 3'b010,
      ST_SETTLE = 3'b100
   } sdm_state_type;
endpackage

// ==== src/sdm_fifo.sv ====
`timescale 1ns/1ns
module sdm_fifo
   import sdm_pkg::*;
#(
   parameter int W     = 8,
   parameter int DEPTH = 32
)(
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         in_valid_in,
   input  wire logic [W-1:0] in_data_in,
   output logic              in_ready_out,
   output logic              out_valid_out,
   output logic [W-1:0]      out_data_out,
   input  wire logic         out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   // ------------------------------------------------------------
   // Storage and pointers
   // ------------------------------------------------------------
   logic [W-1:0] mem_q [DEPTH];   // Word store
   logic [AW-1:0] wptr_q, wptr_d;  // Write pointer
   logic [AW-1:0] rptr_q, rptr_d;  // Read pointer
   logic [AW:0]   cnt_q, cnt_d;    // Words held in store
   logic          ov_q, ov_d;      // Output stage holds a word
   logic [W-1:0]  od_q;            // Output stage data
   logic          push, pop;
   // Output stage counts too, so the whole FIFO holds DEPTH words
   assign in_ready_out  = ((cnt_q + {{AW{1'b0}}, ov_q}) < (AW+1)'(DEPTH));
   assign out_valid_out = ov_q;
   assign out_data_out  = od_q;
   // Next pointer and count values
   always_comb
   begin
      push   = in_valid_in && in_ready_out;
      pop    = (cnt_q != '0) && (!ov_q || out_ready_in);
      wptr_d = push ? AW'(wptr_q + 1'b1) : wptr_q;
      rptr_d = pop ? AW'(rptr_q + 1'b1) : rptr_q;
      cnt_d  = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop && !push)
         cnt_d = cnt_q - 1'b1;
      ov_d = pop ? 1'b1 : (out_ready_in ? 1'b0 : ov_q);
   end
   // Registers; read data always leaves from a flop
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
         ov_q   <= 1'b0;
         od_q   <= '0;
      end
      else
      begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q  <= cnt_d;
         ov_q   <= ov_d;
         if (pop)
            od_q <= mem_q[rptr_q];
      end
      if (push)
         mem_q[wptr_q] <= in_data_in;
   end
endmodule

// ==== src/sdm_top.sv ====
`timescale 1ns/1ns
`include "sdm_cfg.svh"
// Functional notes
// RQ1 - Codes 0..5 route channel sense; 6 high impedance
// RQ2 - Channel off keeps sense pin high impedance
// RQ3 - Code 7 is stand-by, bypass flag invalid
// RQ4 - Bit 3 reads bypass monitor, writes ignored
// RQ5 - Diagnosis word: zero, limp flag, six faults
// RQ6 - Chip select fall starts, rise ends access
// RQ7 - Capture on clock fall, drive on rise
// RQ8 - Modulo 8 counter qualifies received frames
// RQ9 - Select high: ignore inputs, output released
// RQ10 - Select fall loads response into shifter; code picks it at select fall and loads the shifter on the first clock fall
// RQ11 - Before first rise output is error OR input
// RQ12 - Bad bit count sets error, drops command
// RQ13 - Good frame updates addressed register; code drops it and sets error while the frame buffer is full
// RQ14 - Master keeps clock low at select edges
// RQ15 - Frames arrive MSB first, control first
// RQ16 - Response leaves MSB first after rises
// RQ17 - One shifter passes bits on for chaining
// RQ18 - Chain needs eight clocks per device
// RQ19 - Control frame: flag, bank, ones, payload
module sdm_top
   import sdm_pkg::*;
#(
   parameter int FIFO_DEPTH = `SDM_FIFO_DEPTH
)(
   input  wire logic       ref_clk_in,
   input  wire logic       rst_in,
   input  wire logic       sclk_in,
   input  wire logic       cs_n_in,
   input  wire logic       si_in,
   output logic            so_out,
   output logic            so_oe_out,
   input  wire logic [5:0] channel_on_bit_in,
   input  wire logic [5:0] channel_fault_flag_in,
   input  wire logic       limp_home_flag_in,
   input  wire logic       bypass_monitor_flag_in,
   output logic [2:0]      sense_route_out,
   output logic            sense_en_out,
   output logic            standby_out,
   output logic            rx_valid_out,
   output logic [7:0]      rx_data_out,
   input  wire logic       rx_ready_in
);
   // ------------------------------------------------------------
   // Serial clock domain
   // ------------------------------------------------------------
   logic [7:0] shift_q;     // Single shifter shared by in and out
   logic [7:0] shift_d;
   logic       first_q;     // No falling edge yet in this frame
   logic       rose_q;      // A rising edge has been seen
   logic       so_shift_q;  // Bit driven after a rising edge
   logic       so_shift_d;
   logic       fall_tog_q;  // Toggles once per captured bit
   logic [7:0] resp_q;      // Response word, ref domain, static in frame
   // Capture path: the first fall loads the response under the bit
   always_comb
   begin
      shift_d = first_q ? {resp_q[6:0], si_in} : {shift_q[6:0], si_in}; // RQ10 RQ15 RQ17
      so_shift_d = first_q ? resp_q[7] : shift_q[7];                  // RQ16
   end
   // Falling edge: capture one bit
   always_ff @(negedge sclk_in)
   begin
      shift_q <= shift_d;                                             // RQ7
   end
   // Falling edge toggle for the bit counter; reset only by rst_in
   always_ff @(negedge sclk_in or posedge rst_in)
   begin
      if (rst_in)
         fall_tog_q <= 1'b0;
      else
         fall_tog_q <= ~fall_tog_q;
   end
   // Frame start flag; select high rearms it without a clock
   always_ff @(negedge sclk_in or posedge cs_n_in)
   begin
      if (cs_n_in)
         first_q <= 1'b1;                                             // RQ6
      else
         first_q <= 1'b0;
   end
   // Rising edge: drive the displaced bit
   always_ff @(posedge sclk_in)
   begin
      so_shift_q <= so_shift_d;                                       // RQ7
   end
   // Output source select; cleared while deselected
   always_ff @(posedge sclk_in or posedge cs_n_in)
   begin
      if (cs_n_in)
         rose_q <= 1'b0;
      else
         rose_q <= 1'b1;                                              // RQ11
   end
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [17:0] sync1_q;    // First stage, read only by second
   logic [17:0] sync2_q;    // Second stage, safe to use
   logic        tog_prev_q; // Previous synced toggle, for edge
   logic        cs_prev_q;  // Previous synced select
   wire logic [17:0] sync_raw = {fall_tog_q, cs_n_in, si_in, bypass_monitor_flag_in,
                                 limp_home_flag_in, channel_fault_flag_in,
                                 channel_on_bit_in, 1'b0};
   wire logic       tog_s = sync2_q[17];
   wire logic       cs_s  = sync2_q[16];
   wire logic       si_s  = sync2_q[15];
   wire logic       byp_s = sync2_q[14];
   wire logic       lhi_s = sync2_q[13];
   wire logic [5:0] flt_s = sync2_q[12:7];
   wire logic [5:0] on_s  = sync2_q[6:1];
   // Two flops for every pin level and the toggle
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         sync1_q    <= 18'h10000;
         sync2_q    <= 18'h10000;
         tog_prev_q <= 1'b0;
         cs_prev_q  <= 1'b1;
      end
      else
      begin
         sync1_q    <= sync_raw;
         sync2_q    <= sync1_q;
         tog_prev_q <= tog_s;
         cs_prev_q  <= cs_s;
      end
   end
   wire logic cs_fall = cs_prev_q && !cs_s;
   wire logic cs_rise = !cs_prev_q && cs_s;
   wire logic bit_evt = tog_s ^ tog_prev_q;
   // ------------------------------------------------------------
   // Frame tracking and decode
   // ------------------------------------------------------------
   sdm_state_type  state_q, state_d;
   logic [2:0]     bits_q, bits_d;     // Bit count modulo 8
   logic           any_q, any_d;       // At least one bit clocked
   logic [2:0]     settle_q, settle_d; // Lets the last toggle land
   logic           ter_q, ter_d;       // Transmission error flag
   logic [2:0]     mux_q, mux_d;       // Sense multiplexer field
   logic           rd_dcr_q, rd_dcr_d; // Next response is control reg
   logic [7:0]     resp_d;
   logic           so_pre_q, so_pre_d; // Level before first rise
   logic           oe_q, oe_d;
   logic           fifo_ready;
   logic           push;
   sdm_frame_type  frame;
   sdm_diag_type   diag;
   logic           sbm_val;
   logic           good;
   // True when a frame holds a nonzero multiple of eight bits
   function automatic logic frame_ok(input logic [2:0] bits, input logic any);
      frame_ok = any && (bits == 3'h0);
   endfunction
   // Next state of the frame tracker and the registers it steers
   always_comb
   begin
      frame    = sdm_frame_type'(shift_q);
      diag     = '{zero: 1'b0, limp_home_flag: lhi_s, channel_fault_flag: flt_s}; // RQ5
      sbm_val  = (mux_q == `SDM_MUX_STBY) ? 1'b0 : byp_s;                       // RQ3 RQ4
      state_d  = state_q;
      bits_d   = bits_q;
      any_d    = any_q;
      settle_d = settle_q;
      ter_d    = ter_q;
      mux_d    = mux_q;
      rd_dcr_d = rd_dcr_q;
      resp_d   = resp_q;
      good     = frame_ok(bits_q, any_q);
      push     = 1'b0;
      oe_d     = !cs_s;                                               // RQ9
      so_pre_d = ter_q | si_s;                                        // RQ11
      case (state_q)
         ST_IDLE:
         begin
            if (cs_fall)
            begin
               state_d = ST_FRAME;                                    // RQ6
               bits_d  = 3'h0;
               any_d   = 1'b0;
               // Response picked at the start of access
               resp_d  = rd_dcr_q ? {`SDM_DCR_RD_HDR, sbm_val, mux_q} : diag; // RQ10
            end
         end
         ST_FRAME:
         begin
            if (bit_evt)
            begin
               bits_d = bits_q + 3'h1;                                // RQ8
               any_d  = 1'b1;
            end
            if (cs_rise)
            begin
               state_d  = ST_SETTLE;
               settle_d = `SDM_SETTLE_CYC;
            end
         end
         ST_SETTLE:
         begin
            if (bit_evt)
            begin
               bits_d = bits_q + 3'h1;
               any_d  = 1'b1;
            end
            if (settle_q != 3'h0)
               settle_d = settle_q - 3'h1;
            else
            begin
               state_d = ST_IDLE;
               if (good && fifo_ready)
               begin
                  push  = 1'b1;
                  ter_d = 1'b0;
                  rd_dcr_d = 1'b0;
                  if ({frame.bank_bit, frame.addr} == `SDM_SEL_DCR)       // RQ19
                  begin
                     if (frame.wr)
                        mux_d = frame.payload[`SDM_MUX_MSB:`SDM_MUX_LSB]; // RQ13 RQ4
                     else
                        rd_dcr_d = 1'b1;
                  end
               end
               else
                  ter_d = 1'b1;                                       // RQ12
            end
         end
         default:
            state_d = ST_IDLE;
      endcase
   end
   // Tracker registers
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         state_q  <= ST_IDLE;
         bits_q   <= 3'h0;
         any_q    <= 1'b0;
         settle_q <= 3'h0;
         ter_q    <= `SDM_TER_RST;
         mux_q    <= `SDM_MUX_RST;
         rd_dcr_q <= 1'b0;
         resp_q   <= 8'h00;
         so_pre_q <= 1'b0;
         oe_q     <= 1'b0;
      end
      else
      begin
         state_q  <= state_d;
         bits_q   <= bits_d;
         any_q    <= any_d;
         settle_q <= settle_d;
         ter_q    <= ter_d;
         mux_q    <= mux_d;
         rd_dcr_q <= rd_dcr_d;
         resp_q   <= resp_d;
         so_pre_q <= so_pre_d;
         oe_q     <= oe_d;
      end
   end
   // Output picks the pre-clock level until the first rise
   assign so_out    = rose_q ? so_shift_q : so_pre_q;                 // RQ11
   assign so_oe_out = oe_q;                                           // RQ9
   // ------------------------------------------------------------
   // Sense routing
   // ------------------------------------------------------------
   logic [2:0] route_q, route_d;
   logic       sen_q, sen_d;
   logic       stby_q, stby_d;
   // Enable only for a live channel code with that output on
   always_comb
   begin
      route_d = mux_q;
      stby_d  = (mux_q == `SDM_MUX_STBY);                             // RQ3
      sen_d   = (mux_q <= `SDM_MUX_LAST_CH) && on_s[mux_q];           // RQ1 RQ2
   end
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         route_q <= `SDM_MUX_RST;
         sen_q   <= 1'b0;
         stby_q  <= 1'b0;
      end
      else
      begin
         route_q <= route_d;
         sen_q   <= sen_d;
         stby_q  <= stby_d;
      end
   end
   assign sense_route_out = route_q;
   assign sense_en_out    = sen_q;
   assign standby_out     = stby_q;
   // ------------------------------------------------------------
   // Received frame buffer; full buffer refuses the frame
   // ------------------------------------------------------------
   sdm_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_in        (ref_clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (push),
      .in_data_in    (shift_q),
      .in_ready_out  (fifo_ready),
      .out_valid_out (rx_valid_out),
      .out_data_out  (rx_data_out),
      .out_ready_in  (rx_ready_in)
   );
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_bad_sets_ter;
      @(posedge ref_clk_in) disable iff (rst_in)
      (state_q == ST_SETTLE && settle_q == 3'h0 && !good) |=> ter_q;
   endproperty
   a_bad_sets_ter: assert property (p_bad_sets_ter) else $error("bad frame kept error clear"); // RQ12
   property p_bad_no_write;
      @(posedge ref_clk_in) disable iff (rst_in)
      (state_q == ST_SETTLE && !good) |=> $stable(mux_q);
   endproperty
   a_bad_no_write: assert property (p_bad_no_write) else $error("bad frame changed mux"); // RQ8
   property p_write_mux;
      @(posedge ref_clk_in) disable iff (rst_in)
      (push && frame.wr && {frame.bank_bit, frame.addr} == 3'h7)
      |=> (mux_q == $past(shift_q[2:0]));
   endproperty
   a_write_mux: assert property (p_write_mux) else $error("write did not set mux"); // RQ13
   property p_off_no_sense;
      @(posedge ref_clk_in) disable iff (rst_in)
      (mux_q <= 3'h5 && !on_s[mux_q]) |=> !sen_q;
   endproperty
   a_off_no_sense: assert property (p_off_no_sense) else $error("sense on for off channel"); // RQ2
   property p_on_sense;
      @(posedge ref_clk_in) disable iff (rst_in)
      (mux_q <= 3'h5 && on_s[mux_q]) |=> (sen_q && route_q == $past(mux_q));
   endproperty
   a_on_sense: assert property (p_on_sense) else $error("sense not routed"); // RQ1
   property p_standby;
      @(posedge ref_clk_in) disable iff (rst_in)
      (mux_q == 3'h7) |=> (stby_q && !sen_q);
   endproperty
   a_standby: assert property (p_standby) else $error("stand-by not entered"); // RQ3
   property p_oe_follows_cs;
      @(posedge ref_clk_in) disable iff (rst_in)
      cs_s [*2] |-> !so_oe_out;
   endproperty
   a_oe_follows_cs: assert property (p_oe_follows_cs) else $error("output driven while idle"); // RQ9
   property p_diag_resp;
      @(posedge ref_clk_in) disable iff (rst_in)
      (state_q == ST_IDLE && cs_fall && !rd_dcr_q) |=> (resp_q[7] == 1'b0 && resp_q[5:0] == $past(flt_s));
   endproperty
   a_diag_resp: assert property (p_diag_resp) else $error("diagnosis word wrong"); // RQ5 RQ10
   property p_dcr_resp;
      @(posedge ref_clk_in) disable iff (rst_in)
      (state_q == ST_IDLE && cs_fall && rd_dcr_q)
      |=> (resp_q[3] == $past(sbm_val) && resp_q[2:0] == $past(mux_q));
   endproperty
   a_dcr_resp: assert property (p_dcr_resp) else $error("control read word wrong"); // RQ4
   property p_pre_level;
      @(posedge ref_clk_in) disable iff (rst_in)
      1'b1 |=> (so_pre_q == ($past(ter_q) | $past(si_s)));
   endproperty
   a_pre_level: assert property (p_pre_level) else $error("pre-clock level wrong"); // RQ11
   c_good_frame: cover property (@(posedge ref_clk_in) disable iff (rst_in) push);
   c_bad_frame: cover property (@(posedge ref_clk_in) disable iff (rst_in)
      state_q == ST_SETTLE && settle_q == 3'h0 && !good);
   c_fifo_full: cover property (@(posedge ref_clk_in) disable iff (rst_in) !fifo_ready);
   c_dcr_read: cover property (@(posedge ref_clk_in) disable iff (rst_in) rd_dcr_q && cs_fall);
endmodule

// ==== tb/sdm_master_model.sv ====
`timescale 1ns/1ns
// ------------------------------------------------------------
// Serial bus master: drives clock, select and data to the port
// ------------------------------------------------------------
module sdm_master_model
(
   output logic      sclk_out,  // Serial clock, idle low
   output logic      cs_n_out,  // Chip select, active low
   output logic      si_out,    // Data toward device
   input  wire logic so_in,     // Data from device
   input  wire logic so_oe_in   // Device drives its output
);
   // Idle levels: pull-downs hold clock and data low
   initial
   begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      si_out   = 1'b0;
   end

   // One frame of n bits, right aligned in tx; pre is the level before first rise
   task automatic xfer(input logic [23:0] tx, input int n,
                       output logic [23:0] rx, output logic pre);
      int i;
      rx = 24'h000000;
      #7;                                 // Odd offset keeps edges off the ref clock
      cs_n_out = 1'b0;
      if (n > 0)
      begin
         si_out = tx[n-1];
      end
      #60;                                // Device needs 40 ns before first rise
      pre = so_oe_in ? so_in : 1'bx;
      for (i = n - 1; i >= 0; i--)
      begin
         #12 si_out = tx[i];
         #12 sclk_out = 1'b1;
         #23 rx = {rx[22:0], so_in};
         #1 sclk_out = 1'b0;
      end
      #40 cs_n_out = 1'b1;
      #5 si_out = 1'b0;                   // Released data falls to its pull-down
      #200;                               // Covers deselect gap and decode
   endtask

   // Clock and data toggling with select high; must be ignored
   task automatic wiggle();
      repeat (4)
      begin
         si_out = ~si_out;
         #24 sclk_out = 1'b1;
         #24 sclk_out = 1'b0;
      end
      si_out = 1'b0;
   endtask
endmodule

// ==== tb/sdm_top_test.sv ====
`timescale 1ns/1ns
module sdm_top_test;
   import sdm_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        ref_clk_in, rst_in, sclk_in, cs_n_in, si_in, so_out, so_oe_out;
   logic [5:0]  channel_on_bit_in, channel_fault_flag_in;
   logic        limp_home_flag_in, bypass_monitor_flag_in;
   logic [2:0]  sense_route_out;
   logic        sense_en_out, standby_out, rx_valid_out, rx_ready_in;
   logic [7:0]  rx_data_out;
   logic [23:0] rx_word;    // Bits seen by the master
   logic        pre_bit;    // Level before first rise
   int          n_fail, checked;

   initial
   begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end

   // Small FIFO so that it fills within a few frames
   sdm_top #(.FIFO_DEPTH(4)) u_sdm_top (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .sclk_in(sclk_in), .cs_n_in(cs_n_in), .si_in(si_in), .so_out(so_out),
      .so_oe_out(so_oe_out), .channel_on_bit_in(channel_on_bit_in),
      .channel_fault_flag_in(channel_fault_flag_in), .limp_home_flag_in(limp_home_flag_in),
      .bypass_monitor_flag_in(bypass_monitor_flag_in), .sense_route_out(sense_route_out),
      .sense_en_out(sense_en_out), .standby_out(standby_out), .rx_valid_out(rx_valid_out),
      .rx_data_out(rx_data_out), .rx_ready_in(rx_ready_in));

   sdm_master_model u_sdm_master_model (.sclk_out(sclk_in), .cs_n_out(cs_n_in),
      .si_out(si_in), .so_in(so_out), .so_oe_in(so_oe_out));

   // ------------------------------------------------------------
   // Compare helpers
   // ------------------------------------------------------------
   task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic got, input logic exp);
      chk_word({23'h000000, got}, {23'h000000, exp});
   endtask

   task automatic chk_sense(input logic [2:0] r, input logic e, input logic s);
      chk_word({21'h000000, sense_route_out}, {21'h000000, r});
      chk_pin(sense_en_out, e);
      chk_pin(standby_out, s);
   endtask

   task automatic fr(input logic [23:0] tx, input int n);
      u_sdm_master_model.xfer(tx, n, rx_word, pre_bit);
   endtask

   // Take one word from the FIFO, waiting a bounded time
   task automatic pop(input logic [7:0] exp);
      int k;
      @(negedge ref_clk_in);              // Ready stays low a cycle between pops
      for (k = 0; k < 30 && rx_valid_out !== 1'b1; k++)
         @(negedge ref_clk_in);
      chk_pin(rx_valid_out, 1'b1);
      chk_word({16'h0000, rx_data_out}, {16'h0000, exp});
      rx_ready_in = 1'b1;
      @(negedge ref_clk_in);
      rx_ready_in = 1'b0;
   endtask

   task automatic print_verdict();
      if (n_fail == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_first();
      @(negedge ref_clk_in);
      channel_fault_flag_in = 6'h2A;
      limp_home_flag_in     = 1'b1;
      fr(24'h000070, 8);
      chk_pin(pre_bit, 1'b1);
      chk_word(rx_word, 24'h00006A);
      pop(8'h70);
      fr(24'h000070, 8);
      chk_pin(pre_bit, 1'b0);
      chk_word(rx_word, 24'h000076);
      pop(8'h70);
   endtask

   task automatic t_mux();
      int c;
      channel_on_bit_in = 6'h3F;
      for (c = 0; c < 8; c++)
      begin
         fr({16'h0000, 5'h1E, c[2:0]}, 8);
         pop({5'h1E, c[2:0]});
         chk_sense(c[2:0], c <= 5, c == 7);
      end
      @(negedge ref_clk_in);
      channel_on_bit_in = 6'h3B;                     // Channel 2 off
      fr(24'h0000F2, 8);
      pop(8'hF2);
      chk_sense(3'h2, 1'b0, 1'b0);
      fr(24'h0000F3, 8);
      pop(8'hF3);
      chk_sense(3'h3, 1'b1, 1'b0);
   endtask

   task automatic t_read();
      @(negedge ref_clk_in);
      bypass_monitor_flag_in = 1'b1;
      fr(24'h0000F9, 8);
      pop(8'hF9);
      chk_sense(3'h1, 1'b1, 1'b0);
      fr(24'h000070, 8);
      pop(8'h70);
      fr(24'h0000F7, 8);
      chk_word(rx_word, 24'h000079);
      pop(8'hF7);
      chk_sense(3'h7, 1'b0, 1'b1);
      fr(24'h000070, 8);
      pop(8'h70);
      fr(24'h0000F6, 8);
      chk_word(rx_word, 24'h000077);
      pop(8'hF6);
   endtask

   task automatic t_bad();
      int lens[3] = '{0, 7, 9};
      int j;
      for (j = 0; j < 3; j++)
      begin
         fr(24'h0000F1, lens[j]);
         chk_pin(rx_valid_out, 1'b0);
         chk_sense(3'h6, 1'b0, 1'b0);
         fr(24'h000070, 8);
         chk_pin(pre_bit, 1'b1);
         pop(8'h70);
      end
   endtask

   task automatic t_chain();
      @(negedge ref_clk_in);
      channel_on_bit_in = 6'h3F;
      fr(24'h00A5F2, 16);
      chk_word({8'h00, rx_word[15:8], 8'h00}, 24'h007E00);
      chk_word({16'h0000, rx_word[7:0]}, 24'h0000A5);
      pop(8'hF2);
      chk_sense(3'h2, 1'b1, 1'b0);
   endtask

   task automatic t_idle();
      u_sdm_master_model.wiggle();
      chk_pin(so_oe_out, 1'b0);
      chk_pin(rx_valid_out, 1'b0);
      chk_sense(3'h2, 1'b1, 1'b0);
   endtask

   task automatic t_full();
      int j;
      for (j = 0; j < 5; j++)
         fr({16'h0000, 5'h1E, j[2:0]}, 8);
      chk_sense(3'h3, 1'b1, 1'b0);
      for (j = 0; j < 4; j++)
         pop({5'h1E, j[2:0]});
      repeat (4) @(negedge ref_clk_in);
      chk_pin(rx_valid_out, 1'b0);
      fr(24'h000070, 8);
      chk_pin(pre_bit, 1'b1);
      pop(8'h70);
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      n_fail = 0;
      checked = 0;
      rst_in = 1'b1;
      rx_ready_in = 1'b0;
      channel_on_bit_in = 6'h00;
      channel_fault_flag_in = 6'h00;
      limp_home_flag_in = 1'b0;
      bypass_monitor_flag_in = 1'b0;
      repeat (16) @(negedge ref_clk_in);
      chk_pin(so_oe_out, 1'b0);
      chk_sense(3'h6, 1'b0, 1'b0);
      rst_in = 1'b0;
      repeat (4) @(negedge ref_clk_in);
      t_first();
      t_mux();
      t_read();
      t_bad();
      t_chain();
      t_idle();
      t_full();
      print_verdict();
   end

   // About 30 frames of under 1.1 us each; generous margin
   initial
   begin
      #200000;
      n_fail++;
      print_verdict();
   end
endmodule
